//--- rtl/iofa_cfg.svh
// Constants for the I/O function assignment block.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef IOFA_CFG_SVH
`define IOFA_CFG_SVH

`define IOFA_NUM_OUT 8
`define IOFA_NUM_IN 8
`define IOFA_FUNC_W 8
`define IOFA_PORT_W 10
`define IOFA_PROG_W 8
`define IOFA_NUM_SYNC 12
`define IOFA_OUT_BASE 10'h12c
`define IOFA_FN_ALL_HOME 8'h0d
`define IOFA_FN_SYS_BATT 8'h0f
`define IOFA_FN_ABS_BATT 8'h10
`define IOFA_FN_BRAKE_AX1 8'h16
`define IOFA_FN_BRAKE_AX2 8'h17
`define IOFA_SYNC_IN_LSB 0
`define IOFA_SYNC_SYSB 8
`define IOFA_SYNC_ABSB 9
`define IOFA_SYNC_ESTOP 10
`define IOFA_SYNC_GATE 11

`endif

//--- rtl/iofa_pkg.sv
// Types shared by the I/O function assignment block.
// Assumes iofa_cfg.svh is on the include path.
`include "iofa_cfg.svh"

package iofa_pkg;
    typedef enum logic [0:0] {
        iofa_st_idle = 1'b0,
        iofa_st_safe = 1'b1
    } iofa_state_e;
    typedef logic [`IOFA_FUNC_W-1:0] iofa_func_t;
    typedef logic [`IOFA_PORT_W-1:0] iofa_port_t;
endpackage

//--- rtl/iofa_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no word coherence is kept.
`timescale 1ns/1ns

module iofa_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Levels.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule

//--- rtl/iofa_top.sv
// Function assignment for discrete output and input ports of a motion controller.
// Assumes function codes and the hold range are static configuration from the same clock domain.
`timescale 1ns/1ns
`include "iofa_cfg.svh"

module iofa_top (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Port function configuration.
    input wire logic [`IOFA_NUM_OUT*`IOFA_FUNC_W-1:0] out_func_flat,
    input wire logic [`IOFA_NUM_IN*`IOFA_FUNC_W-1:0] in_func_flat,
    input wire logic [`IOFA_PORT_W-1:0] hold_min_port,
    input wire logic [`IOFA_PORT_W-1:0] hold_max_port,
    input wire logic [`IOFA_PROG_W-1:0] safe_prog_num,
    // Controller status.
    input wire logic all_home_done,
    input wire logic [`IOFA_NUM_OUT-1:0] gp_out_val,
    input wire logic [`IOFA_NUM_OUT-1:0] prog_out_val,
    input wire logic [`IOFA_NUM_OUT-1:0] prog_out_we,
    // Field pins.
    input wire logic [`IOFA_NUM_IN-1:0] in_pins,
    input wire logic sys_batt_low,
    input wire logic abs_batt_low,
    input wire logic estop_in,
    input wire logic gate_open,
    // Results.
    output logic [`IOFA_NUM_OUT-1:0] out_port,
    output logic [1:0] brake_release,
    output logic safe_active,
    output logic prog_start,
    output logic [`IOFA_PROG_W-1:0] prog_start_num
);
    logic [`IOFA_NUM_SYNC-1:0] sync_q;
    logic [`IOFA_NUM_IN-1:0] in_s;
    logic sys_batt_s;
    logic abs_batt_s;
    logic safe_s;

    iofa_sync #(.WIDTH(`IOFA_NUM_SYNC)) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({gate_open, estop_in, abs_batt_low, sys_batt_low, in_pins}),
        .sync_out(sync_q)
    );

    assign in_s = sync_q[`IOFA_SYNC_IN_LSB +: `IOFA_NUM_IN];
    assign sys_batt_s = sync_q[`IOFA_SYNC_SYSB];
    assign abs_batt_s = sync_q[`IOFA_SYNC_ABSB];
    assign safe_s = sync_q[`IOFA_SYNC_ESTOP] | sync_q[`IOFA_SYNC_GATE];

    // Safety state and program start.
    iofa_pkg::iofa_state_e state_ff;
    iofa_pkg::iofa_state_e nxt_state;
    logic prog_start_ff;
    logic nxt_prog_start;
    logic [`IOFA_PROG_W-1:0] prog_num_ff;
    logic [`IOFA_PROG_W-1:0] nxt_prog_num;

    always_comb begin
        nxt_state = state_ff;
        nxt_prog_start = 1'b0;
        nxt_prog_num = prog_num_ff;
        case (state_ff)
            iofa_pkg::iofa_st_idle: begin
                if (safe_s) begin
                    nxt_state = iofa_pkg::iofa_st_safe;
                    nxt_prog_start = 1'b1;
                    nxt_prog_num = safe_prog_num;
                end
            end
            iofa_pkg::iofa_st_safe: begin
                if (!safe_s) begin
                    nxt_state = iofa_pkg::iofa_st_idle;
                end
            end
            default: begin
                nxt_state = iofa_pkg::iofa_st_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= iofa_pkg::iofa_st_idle;
            prog_start_ff <= 1'b0;
            prog_num_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            prog_start_ff <= nxt_prog_start;
            prog_num_ff <= nxt_prog_num;
        end
    end

    // Output ports and brake releases.
    logic [`IOFA_NUM_OUT-1:0] out_ff;
    logic [`IOFA_NUM_OUT-1:0] nxt_out;
    logic [`IOFA_NUM_OUT-1:0] in_range;
    logic [1:0] brake_ff;
    logic [1:0] nxt_brake;

    always_comb begin
        iofa_pkg::iofa_func_t code;
        iofa_pkg::iofa_port_t pnum;
        code = '0;
        pnum = '0;
        nxt_out = out_ff;
        in_range = '0;
        nxt_brake = 2'h0;
        for (int i = 0; i < `IOFA_NUM_OUT; i++) begin
            code = out_func_flat[i*`IOFA_FUNC_W +: `IOFA_FUNC_W];
            pnum = `IOFA_OUT_BASE + i[`IOFA_PORT_W-1:0];
            in_range[i] = (pnum >= hold_min_port) && (pnum <= hold_max_port);
            if (safe_s && in_range[i]) begin
                // Held ports change only by the started program.
                if (prog_out_we[i]) begin
                    nxt_out[i] = prog_out_val[i];
                end else begin
                    nxt_out[i] = out_ff[i];
                end
            end else if (code == `IOFA_FN_ALL_HOME) begin
                nxt_out[i] = all_home_done;
            end else if (code == `IOFA_FN_SYS_BATT) begin
                nxt_out[i] = sys_batt_s;
            end else if (code == `IOFA_FN_ABS_BATT) begin
                nxt_out[i] = abs_batt_s;
            end else begin
                nxt_out[i] = gp_out_val[i];
            end
        end
        for (int j = 0; j < `IOFA_NUM_IN; j++) begin
            code = in_func_flat[j*`IOFA_FUNC_W +: `IOFA_FUNC_W];
            if (code == `IOFA_FN_BRAKE_AX1 && in_s[j]) begin
                nxt_brake[0] = 1'b1;
            end
            if (code == `IOFA_FN_BRAKE_AX2 && in_s[j]) begin
                nxt_brake[1] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_ff <= '0;
            brake_ff <= 2'h0;
        end else begin
            out_ff <= nxt_out;
            brake_ff <= nxt_brake;
        end
    end

    assign out_port = out_ff;
    assign brake_release = brake_ff;
    assign safe_active = (state_ff == iofa_pkg::iofa_st_safe);
    assign prog_start = prog_start_ff;
    assign prog_start_num = prog_num_ff;

    // Checks.
    logic [`IOFA_FUNC_W-1:0] code0;
    logic [`IOFA_FUNC_W-1:0] icode0;
    assign code0 = out_func_flat[`IOFA_FUNC_W-1:0];
    assign icode0 = in_func_flat[`IOFA_FUNC_W-1:0];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_HOME_DONE: assert property ((code0 == `IOFA_FN_ALL_HOME) && !(safe_s && in_range[0])
        |=> out_port[0] == $past(all_home_done)) else $error("home-done output wrong");
    AST_SYS_BATT: assert property ((code0 == `IOFA_FN_SYS_BATT) && !(safe_s && in_range[0])
        |=> out_port[0] == $past(sys_batt_s)) else $error("system battery output wrong");
    AST_ABS_BATT: assert property ((code0 == `IOFA_FN_ABS_BATT) && !safe_s && $stable(code0)
        |=> out_port[0] == $past(abs_batt_s)) else $error("encoder battery output wrong");
    AST_BRAKE: assert property ((icode0 == `IOFA_FN_BRAKE_AX1) && in_s[0]
        |=> brake_release[0]) else $error("axis 1 brake not released");
    AST_HOLD: assert property (safe_s && in_range[7] && !prog_out_we[7]
        |=> $stable(out_port[7])) else $error("held output changed");
    AST_START: assert property ($rose(safe_s) && !safe_active
        |=> prog_start && prog_start_num == $past(safe_prog_num) ##1 !prog_start)
        else $error("program start missing");
    AST_PROG_RANGE: assert property (safe_s && !in_range[0] && code0 == `IOFA_FN_ALL_HOME
        |=> out_port[0] == $past(all_home_done)) else $error("program reached outside range");
    AST_GP: assert property (!safe_s && code0 == 8'h00
        |=> out_port[0] == $past(gp_out_val[0])) else $error("general output altered");

    COV_START: cover property ($rose(prog_start));
    COV_HOLD: cover property (safe_s && in_range[7] ##1 safe_s [*3]);
    COV_PROG_WRITE: cover property (safe_s && in_range[7] && prog_out_we[7]);
    COV_BRAKE: cover property ($rose(brake_release[0]));
endmodule

//--- tb/iofa_field.sv
// Behavioural model of the output-processing program that runs on a safety stop.
// Assumes the block's one-cycle prog_start pulse and the shared core_clk.
`timescale 1ns/1ns

module iofa_field (
    // Clock.
    input wire logic core_clk,
    // Start request and program writes.
    input wire logic prog_start,
    output logic [7:0] prog_out_val,
    output logic [7:0] prog_out_we
);
    // The program writes every port, out-of-range ones too, and never commands an axis.
    initial begin
        prog_out_val = 8'h55;
        prog_out_we = 8'h00;
        forever begin
            @(posedge core_clk);
            if (prog_start === 1'b1) begin
                repeat (3) @(posedge core_clk);
                #1 prog_out_we = 8'hff;
                @(posedge core_clk);
                #1 prog_out_we = 8'h00;
                // A released data bus must not keep showing the written value.
                prog_out_val = ~prog_out_val;
            end
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking testbench for the I/O function assignment block.
// Assumes the design files and iofa_field.sv are compiled first.
`timescale 1ns/1ns

module tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [63:0] out_func_flat = 64'h0;
    logic [63:0] in_func_flat = 64'h0;
    logic [9:0] hold_min_port = 10'h12f;
    logic [9:0] hold_max_port = 10'h133;
    logic [7:0] safe_prog_num = 8'h05;
    logic all_home_done = 1'b0;
    logic [7:0] gp_out_val = 8'h00;
    logic [7:0] prog_out_val;
    logic [7:0] prog_out_we;
    logic [7:0] in_pins = 8'h00;
    logic sys_batt_low = 1'b0;
    logic abs_batt_low = 1'b0;
    logic estop_in = 1'b0;
    logic gate_open = 1'b0;
    logic [7:0] out_port;
    logic [1:0] brake_release;
    logic safe_active;
    logic prog_start;
    logic [7:0] prog_start_num;
    int failures = 0;
    int total_checks = 0;

    iofa_top uut (.core_clk(core_clk), .reset_n(reset_n), .out_func_flat(out_func_flat),
        .in_func_flat(in_func_flat), .hold_min_port(hold_min_port), .hold_max_port(hold_max_port),
        .safe_prog_num(safe_prog_num), .all_home_done(all_home_done), .gp_out_val(gp_out_val),
        .prog_out_val(prog_out_val), .prog_out_we(prog_out_we), .in_pins(in_pins),
        .sys_batt_low(sys_batt_low), .abs_batt_low(abs_batt_low), .estop_in(estop_in),
        .gate_open(gate_open), .out_port(out_port), .brake_release(brake_release),
        .safe_active(safe_active), .prog_start(prog_start), .prog_start_num(prog_start_num));

    iofa_field field (.core_clk(core_clk), .prog_start(prog_start), .prog_out_val(prog_out_val),
        .prog_out_we(prog_out_we));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic test_out_funcs();
        logic [2:0] c;
        out_func_flat = 64'h0000_0000_0010_0f0d;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            all_home_done = c[0];
            sys_batt_low = c[1];
            abs_batt_low = c[2];
            gp_out_val = {c, c[1:0], 3'b101};
            step(5);
            check(out_port, {c, c[1:0], c});
        end
        $display("test out_funcs done");
    endtask

    task automatic test_brake();
        in_func_flat = 64'h0000_0000_0000_1716;
        for (int i = 0; i < 4; i++) begin
            in_pins = {6'h3f, i[1:0]};
            step(5);
            check({6'h00, brake_release}, {6'h00, i[1:0]});
        end
        $display("test brake done");
    endtask

    task automatic test_safe_stop();
        bit seen;
        // Port 300 keeps its home-done function outside the held range.
        out_func_flat = 64'h0000_0000_0000_000d;
        all_home_done = 1'b1;
        for (int k = 0; k < 2; k++) begin
            safe_prog_num = (k == 0) ? 8'h05 : 8'h09;
            gp_out_val = 8'hf8;
            step(3);
            if (k == 0) estop_in = 1'b1;
            else gate_open = 1'b1;
            seen = 0;
            for (int w = 0; w < 10 && !seen; w++) begin
                step(1);
                seen = (prog_start === 1'b1);
            end
            if (!seen) begin
                failures++;
                final_report();
            end
            check(prog_start_num, safe_prog_num);
            check({7'h00, safe_active}, 8'h01);
            gp_out_val = 8'h00;
            step(1);
            check({7'h00, prog_start}, 8'h00);
            check(out_port, 8'hf9);
            step(5);
            check(out_port, (k == 0) ? 8'h51 : 8'ha9);
            estop_in = 1'b0;
            gate_open = 1'b0;
            step(6);
            check({7'h00, safe_active}, 8'h00);
            check(out_port, 8'h01);
        end
        $display("test safe_stop done");
    endtask

    initial begin
        step(12);
        reset_n = 1'b1;
        step(2);
        test_out_funcs();
        test_brake();
        test_safe_stop();
        final_report();
    end
endmodule
